// file: hdl/smw_pkg.sv
// ------------------------------------------------------------
// shared window constants and carriers
// ------------------------------------------------------------
package smw_pkg;
  localparam int ADDR_W = 14;
  localparam int REG_W = 16;
  localparam int EV_W = 3;
  // register indexes, byte address is four times the index
  localparam logic [11:0] IDX_BASE1 = 12'h10C;
  localparam logic [11:0] IDX_RDLIM1 = 12'h110;
  localparam logic [11:0] IDX_WRLIM1 = 12'h112;
  localparam logic [11:0] IDX_SET = 12'h114;
  localparam logic [11:0] IDX_CLREN = 12'h116;
  localparam logic [11:0] IDX_EV_STAT = 12'h118;
  localparam logic [11:0] IDX_EV_MASK = 12'h11A;
  localparam logic [11:0] IDX_PTR = 12'h11C;
  // field layout
  localparam int REGION_BIT = 15;
  localparam int LIM_HI = 14;
  localparam int LIM_LO = 2;
  localparam logic [15:0] LIM_MASK = 16'h7FFC;
  localparam logic [15:0] SRC_MASK = 16'hFFFE;
  localparam logic [31:0] BASE_MASK = 32'hFFFFFFFC;
  localparam logic [16:0] PTR_PAD = 17'h00000;
  // reset values
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [31:0] RST32 = 32'h00000000;
  localparam logic [2:0] RST_EV = 3'h0;
  // event bits
  localparam int EV_WR_BLOCK = 0;
  localparam int EV_RD_BLOCK = 1;
  localparam int EV_RD_LOAD = 2;

  typedef struct packed {
    logic ptr_we;
    logic [15:0] ptr;
    logic data_we;
    logic [3:0] be;
    logic [31:0] wdata;
    logic data_re;
    logic src_we;
    logic [15:0] src_wdata;
  } smw_host_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } smw_mem_req_t;
endpackage : smw_pkg

// file: hdl/smw_window_eng.sv
`timescale 1ns/1ps
`default_nettype none
module smw_window_eng (
  input wire logic clk,
  input wire logic rst_n,
  input wire smw_pkg::smw_host_req_t host,
  input wire logic [31:0] base1,
  input wire logic [15:0] rd_lim,
  input wire logic [15:0] wr_lim,
  output smw_pkg::smw_mem_req_t mem,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] window_data_port,
  output logic [15:0] window_pointer,
  output logic busy,
  output logic [2:0] ev_pulse
);
  typedef enum logic [0:0] {ENG_IDLE, ENG_WAIT} smw_phase_t;
  typedef struct packed {
    smw_phase_t phase;
    logic [15:0] ptr;
    logic [31:0] data;
    smw_pkg::smw_mem_req_t mem;
    logic [2:0] ev;
  } smw_eng_t;

  smw_eng_t st;
  smw_eng_t next_st;
  logic in_region;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] tgt_addr;

  // ------------------------------------------------------------
  // window access decisions
  // ------------------------------------------------------------
  assign in_region = st.ptr[smw_pkg::REGION_BIT];
  assign wr_ok = st.ptr[smw_pkg::LIM_HI:smw_pkg::LIM_LO] <
                 wr_lim[smw_pkg::LIM_HI:smw_pkg::LIM_LO];
  assign rd_ok = st.ptr[smw_pkg::LIM_HI:smw_pkg::LIM_LO] <
                 rd_lim[smw_pkg::LIM_HI:smw_pkg::LIM_LO];
  // bit 15 only selects the region, it is not part of the offset
  assign tgt_addr = base1 + {smw_pkg::PTR_PAD, st.ptr[14:0]};

  // data accesses use the pointer held before any same-cycle update
  always_comb begin
    next_st = st;
    next_st.mem.req = 1'b0;
    next_st.ev = smw_pkg::RST_EV;
    if (host.ptr_we) begin
      next_st.ptr = host.ptr;
    end
    case (st.phase)
      ENG_IDLE: begin
        if (host.data_we) begin
          for (int i = 0; i < 4; i++) begin
            if (host.be[i]) begin
              next_st.data[8*i +: 8] = host.wdata[8*i +: 8];
            end
          end
          if (in_region && wr_ok) begin
            next_st.mem = '{1'b1, 1'b1, tgt_addr, host.be, host.wdata};
          end else if (in_region) begin
            next_st.ev[smw_pkg::EV_WR_BLOCK] = 1'b1;
          end
        end else if (host.data_re && in_region) begin
          if (rd_ok) begin
            next_st.mem = '{1'b1, 1'b0, tgt_addr, 4'hF, st.data};
            next_st.phase = ENG_WAIT;
          end else begin
            next_st.ev[smw_pkg::EV_RD_BLOCK] = 1'b1;
          end
        end
      end
      ENG_WAIT: begin
        if (mem_rvalid) begin
          next_st.data = mem_rdata;
          next_st.ev[smw_pkg::EV_RD_LOAD] = 1'b1;
          next_st.phase = ENG_IDLE;
        end
      end
      default: next_st.phase = ENG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mem = st.mem;
  assign window_data_port = st.data;
  assign window_pointer = st.ptr;
  assign busy = (st.phase == ENG_WAIT);
  assign ev_pulse = st.ev;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_wr_commit_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (host.data_we && !busy && in_region && wr_ok) |=> (mem.req && mem.we))
    else $error("allowed window write not committed");
  chk_wr_suppress: assert property (@(posedge clk) disable iff (!rst_n)
    (host.data_we && !busy && in_region && !wr_ok)
      |=> (!mem.req && ev_pulse[smw_pkg::EV_WR_BLOCK]))
    else $error("window write above ceiling reached memory");
  chk_mem_target: assert property (@(posedge clk) disable iff (!rst_n)
    mem.req |-> (mem.addr == $past(tgt_addr)))
    else $error("memory target not base plus pointer");
  chk_rd_block: assert property (@(posedge clk) disable iff (!rst_n)
    (host.data_re && !host.data_we && !busy && in_region && !rd_ok)
      |=> (!mem.req && $stable(window_data_port)))
    else $error("window read above ceiling loaded data");
  chk_rd_load: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && mem_rvalid) |=> (window_data_port == $past(mem_rdata) && !busy))
    else $error("read data not loaded into window");
endmodule : smw_window_eng
`default_nettype wire

// file: hdl/smw_regs.sv
// Contract
// - host data writes with pointer bit 15 set are checked against region 1 ceiling.
// - bytes commit to internal memory only while pointer 14:2 below ceiling 14:2.
// - pointer 14:2 at or above the ceiling suppresses the memory write; the window data port still takes the bytes.
// - writing one to set bits 15:1 forces source bit; zero leaves it.
// - reading the set register returns current interrupt source bits.
// - clear permission zero makes host clears of that source bit ignored.
// - clear permission one lets a host one-write clear the source bit.
// - region 1 accesses target base address plus window pointer bits 14:0.
// - region 1 host reads load data only while pointer is below read ceiling.
`timescale 1ns/1ps
`default_nettype none
module smw_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [smw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire smw_pkg::smw_host_req_t host,
  output logic [15:0] soft_irq_source,
  output logic [31:0] window_data_port,
  output logic [15:0] window_pointer,
  output logic host_busy,
  output smw_pkg::smw_mem_req_t mem,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] base1;
    logic [15:0] rd_lim;
    logic [15:0] wr_lim;
    logic [15:0] clren;
    logic [15:0] src;
    logic [2:0] ev_stat;
    logic [2:0] ev_mask;
    logic [31:0] rdata;
  } smw_regs_t;

  smw_regs_t st;
  smw_regs_t next_st;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rd_val;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;
  logic [15:0] src_locked;
  logic [2:0] ev_pulse;
  logic [2:0] ev_clr;

  // index match, bits 1:0 of the byte address are ignored
  function automatic logic idx_hit(
    input logic [smw_pkg::ADDR_W-1:0] a,
    input logic [11:0] idx
  );
    idx_hit = (a[smw_pkg::ADDR_W-1:2] == idx);
  endfunction : idx_hit

  // ------------------------------------------------------------
  // window engine
  // ------------------------------------------------------------
  smw_window_eng u_eng (
    .clk(clk),
    .rst_n(rst_n),
    .host(host),
    .base1(st.base1),
    .rd_lim(st.rd_lim),
    .wr_lim(st.wr_lim),
    .mem(mem),
    .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata),
    .window_data_port(window_data_port),
    .window_pointer(window_pointer),
    .busy(host_busy),
    .ev_pulse(ev_pulse)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable;

  // read value is latched in setup so prdata comes from a flop
  always_comb begin
    mapped = 1'b1;
    rd_val = smw_pkg::RST32;
    if (idx_hit(paddr, smw_pkg::IDX_BASE1)) begin
      rd_val = st.base1;
    end else if (idx_hit(paddr, smw_pkg::IDX_RDLIM1)) begin
      rd_val = {smw_pkg::RST16, st.rd_lim};
    end else if (idx_hit(paddr, smw_pkg::IDX_WRLIM1)) begin
      rd_val = {smw_pkg::RST16, st.wr_lim};
    end else if (idx_hit(paddr, smw_pkg::IDX_SET)) begin
      rd_val = {smw_pkg::RST16, st.src};
    end else if (idx_hit(paddr, smw_pkg::IDX_CLREN)) begin
      rd_val = {smw_pkg::RST16, st.clren};
    end else if (idx_hit(paddr, smw_pkg::IDX_EV_STAT)) begin
      rd_val = 32'(st.ev_stat);
    end else if (idx_hit(paddr, smw_pkg::IDX_EV_MASK)) begin
      rd_val = 32'(st.ev_mask);
    end else if (idx_hit(paddr, smw_pkg::IDX_PTR)) begin
      rd_val = {smw_pkg::RST16, window_pointer};
    end else begin
      mapped = 1'b0;
    end
  end

  // zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = st.rdata;

  // ------------------------------------------------------------
  // interrupt source bits
  // ------------------------------------------------------------
  // only one-bits of the set field act, bit 0 never stored
  assign set_bits = (access && pwrite && idx_hit(paddr, smw_pkg::IDX_SET))
                    ? (pwdata[15:0] & smw_pkg::SRC_MASK)
                    : smw_pkg::RST16;
  // host clears pass only where the permission bit is one
  assign clr_bits = host.src_we
                    ? (host.src_wdata & st.clren & smw_pkg::SRC_MASK)
                    : smw_pkg::RST16;
  // bits the host may not clear, watched by the checks below
  assign src_locked = st.src & ~st.clren;

  // event status write-one-to-clear from software
  assign ev_clr = (access && pwrite && idx_hit(paddr, smw_pkg::IDX_EV_STAT))
                  ? pwdata[2:0] : smw_pkg::RST_EV;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (setup && !pwrite) begin
      next_st.rdata = rd_val;
    end
    if (access && pwrite) begin
      if (idx_hit(paddr, smw_pkg::IDX_BASE1)) begin
        next_st.base1 = pwdata & smw_pkg::BASE_MASK;
      end else if (idx_hit(paddr, smw_pkg::IDX_RDLIM1)) begin
        next_st.rd_lim = pwdata[15:0] & smw_pkg::LIM_MASK;
      end else if (idx_hit(paddr, smw_pkg::IDX_WRLIM1)) begin
        next_st.wr_lim = pwdata[15:0] & smw_pkg::LIM_MASK;
      end else if (idx_hit(paddr, smw_pkg::IDX_CLREN)) begin
        next_st.clren = pwdata[15:0] & smw_pkg::SRC_MASK;
      end else if (idx_hit(paddr, smw_pkg::IDX_EV_MASK)) begin
        next_st.ev_mask = pwdata[2:0];
      end
    end
    // set wins over a clear landing in the same cycle
    next_st.src = (st.src & ~clr_bits) | set_bits;
    next_st.ev_stat = (st.ev_stat & ~ev_clr) | ev_pulse;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign soft_irq_source = st.src;
  // level output, stays high until software clears the cause
  assign irq = |(st.ev_stat & st.ev_mask);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_set_forces: assert property (@(posedge clk) disable iff (!rst_n)
    (set_bits != smw_pkg::RST16)
      |=> ((st.src & $past(set_bits)) == $past(set_bits)))
    else $error("set write did not force source bits");
  chk_set_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && idx_hit(paddr, smw_pkg::IDX_SET))
      |=> (prdata[15:0] == $past(st.src)))
    else $error("set read does not show source bits");
  chk_clear_locked: assert property (@(posedge clk) disable iff (!rst_n)
    host.src_we |=> ((st.src & $past(src_locked)) == $past(src_locked)))
    else $error("locked source bit was cleared");
  chk_clear_allowed: assert property (@(posedge clk) disable iff (!rst_n)
    (host.src_we && set_bits == smw_pkg::RST16)
      |=> ((st.src & $past(clr_bits)) == smw_pkg::RST16))
    else $error("permitted source clear did not act");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (!st.src[0] && !st.clren[0] && st.wr_lim[15] == 1'b0
      && st.wr_lim[1:0] == 2'h0))
    else $error("reserved bit holds a one");

  // ------------------------------------------------------------
  // checks on sticky bits, register fields and readback
  // ------------------------------------------------------------
  // a source bit rises only where a one was written to the set field
  chk_src_rise_set: assert property (@(posedge clk) disable iff (!rst_n)
    ((st.src & ~$past(st.src) & ~$past(set_bits)) == smw_pkg::RST16))
    else $error("source bit rose without a set write");

  // a source bit falls only through a permitted host clear
  chk_src_fall_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ((~st.src & $past(st.src) & ~$past(clr_bits)) == smw_pkg::RST16))
    else $error("source bit fell without a permitted clear");

  // set and clear on one bit in one cycle leaves it set
  chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ((set_bits & clr_bits) != smw_pkg::RST16)
      |=> ((st.src & $past(set_bits & clr_bits)) == $past(set_bits & clr_bits)))
    else $error("clear beat a same-cycle set");

  // no set and no clear keeps every source bit as it was
  chk_src_zero_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!host.src_we && set_bits == smw_pkg::RST16)
      |=> $stable(st.src))
    else $error("source bits moved without a set or clear");

  // read data stands until the next read setup
  chk_rdata_stands: assert property (@(posedge clk) disable iff (!rst_n)
    !(setup && !pwrite)
      |=> $stable(prdata))
    else $error("read data changed outside a read setup");

  // a write to an unmapped index must not touch any register
  chk_unmapped_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (access && pwrite && !mapped)
      |=> ($stable(st.base1) && $stable(st.rd_lim) && $stable(st.wr_lim)
        && $stable(st.clren) && $stable(st.ev_mask)))
    else $error("unmapped write changed a register");

  // an unmapped read returns zero
  chk_rd_err_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && !mapped)
      |=> (prdata == smw_pkg::RST32))
    else $error("unmapped read returned data");

  // ceiling keeps only bits 14:2 of what was written
  chk_wrlim_write: assert property (@(posedge clk) disable iff (!rst_n)
    (access && pwrite && idx_hit(paddr, smw_pkg::IDX_WRLIM1))
      |=> (st.wr_lim == ($past(pwdata[15:0]) & smw_pkg::LIM_MASK)))
    else $error("write ceiling field not stored as written");

  // clear permission keeps only bits 15:1 of what was written
  chk_clren_write: assert property (@(posedge clk) disable iff (!rst_n)
    (access && pwrite && idx_hit(paddr, smw_pkg::IDX_CLREN))
      |=> (st.clren == ($past(pwdata[15:0]) & smw_pkg::SRC_MASK)))
    else $error("clear permission not stored as written");

  // base address is word aligned, low bits dropped
  chk_base_write: assert property (@(posedge clk) disable iff (!rst_n)
    (access && pwrite && idx_hit(paddr, smw_pkg::IDX_BASE1))
      |=> (st.base1 == ($past(pwdata) & smw_pkg::BASE_MASK)))
    else $error("base address not stored as written");

  // pointer readback shows the live window pointer
  chk_ptr_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && idx_hit(paddr, smw_pkg::IDX_PTR))
      |=> (prdata == {smw_pkg::RST16, $past(window_pointer)}))
    else $error("pointer read does not show the pointer");

  // ceiling readback shows the stored field only
  chk_ceiling_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && idx_hit(paddr, smw_pkg::IDX_WRLIM1))
      |=> (prdata == {smw_pkg::RST16, $past(st.wr_lim)}))
    else $error("ceiling read does not show the field");

  // set register read keeps its reserved bits at zero
  chk_set_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && idx_hit(paddr, smw_pkg::IDX_SET))
      |=> (prdata[31:16] == smw_pkg::RST16 && !prdata[0]))
    else $error("set read shows a reserved one");

  // every engine event lands in the status bits
  chk_ev_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_pulse != smw_pkg::RST_EV)
      |=> ((st.ev_stat & $past(ev_pulse)) == $past(ev_pulse)))
    else $error("window event not captured");

  // status bits fall only where software wrote a one
  chk_ev_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    ((~st.ev_stat & $past(st.ev_stat) & ~$past(ev_clr)) == smw_pkg::RST_EV))
    else $error("event status fell without a clear");

  // a pending read blocks any memory write
  chk_busy_no_write: assert property (@(posedge clk) disable iff (!rst_n)
    host_busy |-> !(mem.req && mem.we))
    else $error("memory write issued during a pending read");
endmodule : smw_regs
`default_nettype wire

// file: tb/smw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// internal memory seen through the window
// ------------------------------------------------------------
module smw_mem_model #(
  parameter logic [31:0] KEY = 32'h5A5A0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire smw_pkg::smw_mem_req_t mem,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [1:0] cnt;
  logic [31:0] addr;
  // answer reads after one to three cycles; idle data toggles so no stale word looks valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h00000000;
      cnt <= 2'h0;
      addr <= 32'h00000000;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
        if (cnt == 2'h1) begin
          mem_rvalid <= 1'b1;
          mem_rdata <= addr ^ KEY;
        end
      end else if (mem.req && !mem.we) begin
        addr <= mem.addr;
        cnt <= 2'(1 + $urandom % 3);
      end
    end
  end
endmodule : smw_mem_model
`default_nettype wire

// file: tb/smw_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// self-checking bench for the window register bank
// ------------------------------------------------------------
module smw_regs_tb_top;
  localparam logic [31:0] KEY = 32'h5A5A0000;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, irq, busy, rv, err;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, wdp, rdat, r, base, v;
  logic [15:0] src, wptr;
  smw_pkg::smw_host_req_t host = '0, h;
  smw_pkg::smw_mem_req_t mem;
  int miscompares = 0, tests_run = 0, cyc = 0, src_m = 0, n;
  logic [11:0] ix [3] = '{smw_pkg::IDX_WRLIM1, smw_pkg::IDX_SET, smw_pkg::IDX_CLREN};

  always #2.5 clk = ~clk;

  smw_regs dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host(host), .soft_irq_source(src), .window_data_port(wdp), .window_pointer(wptr),
    .host_busy(busy), .mem(mem), .mem_rvalid(rv), .mem_rdata(rdat), .irq(irq));
  smw_mem_model #(.KEY(KEY)) mm (.clk(clk), .rst_n(rst_n), .mem(mem), .mem_rvalid(rv),
    .mem_rdata(rdat));

  task summarize;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one APB transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no wait limit here: the hang guard ends a stuck transfer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle host pulse, then watch three cycles for a memory request
  task pulse(input smw_pkg::smw_host_req_t hv, input logic ok, input logic [31:0] a,
      input logic we);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    host <= hv;
    @(posedge clk);
    host <= '0;
    repeat (3) begin
      @(posedge clk);
      if (mem.req === 1'b1) begin
        seen = 1'b1;
        chk("mem_addr", a, mem.addr);
        chk("mem_we", 32'(we), 32'(mem.we));
        chk("mem_be", 32'(hv.be), 32'(mem.be));
        if (we) begin
          chk("mem_wdata", hv.wdata, mem.wdata);
        end
      end
    end
    chk("mem_req", 32'(ok), 32'(seen));
  endtask : pulse

  // point the window, then read or write through it
  task acc(input logic [15:0] p, input logic wr, input logic ok);
    h = '0;
    h.ptr_we = 1'b1;
    h.ptr = p;
    pulse(h, 1'b0, 32'h0, 1'b0);
    chk("pointer", 32'(p), 32'(wptr));
    h = '0;
    h.data_we = wr;
    h.data_re = !wr;
    h.be = 4'hF;
    h.wdata = $urandom;
    pulse(h, ok, base + {17'h00000, p[14:0]}, wr);
    if (wr) begin
      chk("data_write", h.wdata, wdp);
    end
  endtask : acc

  // ------------------------------------------------------------
  // hang guard
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h5B24));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ix[i], 32'h0);
      chk("reset_val", 32'h0, r);
    end
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    chk("unmapped_err", 32'h1, 32'(err));
    // random set words; zero bits must leave sources alone
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      src_m |= int'(v[15:0] & 16'hFFFE);
      apb(1'b1, smw_pkg::IDX_SET, v);
      apb(1'b0, smw_pkg::IDX_SET, 32'h0);
      chk("set_read", 32'(src_m), r);
      chk("src_out", 32'(src_m), 32'(src));
    end
    v = $urandom;
    apb(1'b1, smw_pkg::IDX_CLREN, v);
    apb(1'b0, smw_pkg::IDX_CLREN, 32'h0);
    chk("clren_read", {16'h0, v[15:0] & 16'hFFFE}, r);
    h = '0;
    h.src_we = 1'b1;
    h.src_wdata = 16'($urandom);
    pulse(h, 1'b0, 32'h0, 1'b0);
    src_m &= ~int'(v[15:0] & h.src_wdata);
    chk("src_clear", 32'(src_m), 32'(src));
    apb(1'b1, smw_pkg::IDX_WRLIM1, 32'hFFFFFFFF);
    chk("mapped_err", 32'h0, 32'(err));
    apb(1'b0, smw_pkg::IDX_WRLIM1, 32'h0);
    chk("wrlim_read", 32'h7FFC, r);
    base = $urandom & 32'hFFFFFFFC;
    apb(1'b1, smw_pkg::IDX_BASE1, base);
    apb(1'b1, smw_pkg::IDX_WRLIM1, 32'h0100);
    apb(1'b1, smw_pkg::IDX_RDLIM1, 32'h0200);
    apb(1'b1, smw_pkg::IDX_EV_MASK, 32'h7);
    acc(16'h80FC, 1'b1, 1'b1);
    chk("irq_quiet", 32'h0, 32'(irq));
    acc(16'h8100, 1'b1, 1'b0);
    chk("irq_block", 32'h1, 32'(irq));
    apb(1'b1, smw_pkg::IDX_EV_STAT, 32'h7);
    @(posedge clk);
    chk("irq_clear", 32'h0, 32'(irq));
    acc(16'h0010, 1'b1, 1'b0);
    acc(16'h81F8, 1'b0, 1'b1);
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    chk("window_data", (base + 32'h01F8) ^ KEY, wdp);
    @(posedge clk);
    chk("irq_load", 32'h1, 32'(irq));
    acc(16'h8200, 1'b0, 1'b0);
    chk("window_hold", (base + 32'h01F8) ^ KEY, wdp);
    summarize();
  end
endmodule : smw_regs_tb_top
`default_nettype wire
